/* File: bench/ixm_chk.sv */
`timescale 1ns/1ps
module ixm_chk (
	// watched ports
	input wire ref_clk,
	input wire sys_rst,
	input wire instr_valid,
	input wire [15:0] instr_word,
	input wire [1:0] phase_q,
	input wire mem_rd_en_q,
	input wire mem_wr_en_q,
	input wire stack_push_q,
	input wire pc_load_q,
	input wire busy_q,
	input wire seq_error_q
);
// ----
// timing relations
// ----
default clocking @(posedge ref_clk); endclocking
default disable iff (sys_rst);
sequence s_q1; phase_q == 2'h0 && instr_valid && !busy_q; endsequence
sequence s_mv; s_q1 ##0 instr_word[15:8] == 8'heb; endsequence
sequence s_call; s_q1 ##0 instr_word == 16'h0014; endsequence
sequence s_w2; instr_valid && instr_word[15:12] == 4'hf; endsequence
sequence s_nw2; !(instr_valid && instr_word[15:12] == 4'hf); endsequence
chk_rd_pulse: assert property (s_mv |-> ##3 mem_rd_en_q ##1 !mem_rd_en_q)
	else $error("source read strobe misplaced");
chk_wr_time: assert property (s_mv ##0 !instr_word[7] ##4 s_w2 |-> ##3 mem_wr_en_q)
	else $error("destination write missing");
chk_no_early: assert property (s_mv |-> ##1 !mem_wr_en_q [*6])
	else $error("write before second cycle");
chk_bad_word: assert property (s_mv ##4 s_nw2 |-> ##[1:4] seq_error_q)
	else $error("bad second word not flagged");
chk_call_seq: assert property (s_call |-> ##2 stack_push_q ##1 pc_load_q)
	else $error("call push or load misplaced");
chk_busy_len: assert property (s_call |-> ##1 busy_q [*7] ##1 !busy_q)
	else $error("call length wrong");
chk_q4_only: assert property ((mem_rd_en_q || mem_wr_en_q) |-> phase_q == 2'h3)
	else $error("memory access outside last phase");
chk_idle_quiet: assert property (!busy_q |-> !mem_wr_en_q && !pc_load_q)
	else $error("activity while idle");
endmodule // ixm_chk

bind ixm_indexed_move_exec ixm_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.instr_valid(instr_valid), .instr_word(instr_word), .phase_q(phase_q),
	.mem_rd_en_q(mem_rd_en_q), .mem_wr_en_q(mem_wr_en_q), .stack_push_q(stack_push_q),
	.pc_load_q(pc_load_q), .busy_q(busy_q), .seq_error_q(seq_error_q));

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
// ----
// stimulus and scenarios
// ----
reg ref_clk = 0, sys_rst = 1, instr_valid = 0;
reg [15:0] instr_word = 0;
reg [11:0] frame_pointer = 0;
reg [7:0] working_register = 8'h06, pc_high_latch = 8'h10, pc_upper_latch = 8'h00;
reg [20:0] pc_value = 21'h000100;
wire [7:0] mem_rd_data, mem_wr_data_q;
wire mem_rd_en_q, mem_wr_en_q, stack_push_q, pc_load_q, busy_q, seq_error_q;
wire [11:0] mem_addr_q;
wire [20:0] stack_push_data_q, pc_load_value_q;
wire [1:0] phase_q;
reg [7:0] mem [0:4095];
reg [20:0] push_v, load_v;
integer n_fail = 0, n_compared = 0, n_err = 0, cyc = 0;
ixm_indexed_move_exec dut (.ref_clk, .sys_rst, .instr_valid, .instr_word, .frame_pointer,
	.working_register, .pc_high_latch, .pc_upper_latch, .pc_value, .mem_rd_data,
	.mem_rd_en_q, .mem_wr_en_q, .mem_addr_q, .mem_wr_data_q, .stack_push_q,
	.stack_push_data_q, .pc_load_q, .pc_load_value_q, .phase_q, .busy_q, .seq_error_q);
initial forever #5 ref_clk = ~ref_clk;
// read data follows the address at once, as the core's data memory does
assign mem_rd_data = mem[mem_addr_q];
always @(posedge ref_clk)
begin
	cyc <= cyc + 1;
	if (mem_wr_en_q === 1'h1)
		mem[mem_addr_q] <= mem_wr_data_q;
	if (stack_push_q === 1'h1)
		push_v <= stack_push_data_q;
	if (pc_load_q === 1'h1)
		load_v <= pc_load_value_q;
	if (seq_error_q === 1'h1)
		n_err <= n_err + 1;
	if (cyc == 1000)
	begin
		n_fail = n_fail + 1;
		wrap_up;
	end
end
task chk(input [20:0] s, e);
	n_compared = n_compared + 1;
	if (s !== e)
	begin
		n_fail = n_fail + 1;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask
// words are offered only at a Q1 edge, so wait out the Q4 before it
task put(input [15:0] w);
	do @(negedge ref_clk); while (phase_q !== 2'h3);
	@(posedge ref_clk);
	instr_valid <= 1'h1;
	instr_word <= w;
	@(posedge ref_clk);
	instr_valid <= 1'h0;
endtask
// destinations avoid the pc and stack top bytes
task mv(input [11:0] fp, input [15:0] w1, w2, input [11:0] dst, input [7:0] e);
	frame_pointer <= fp;
	put(w1);
	put(w2);
	repeat (8) @(posedge ref_clk);
	chk(mem[dst], e);
endtask
task t_file;
	mem[12'h085] <= 8'h33;
	mv(12'h080, 16'heb05, 16'hf123, 12'h123, 8'h33);
endtask
task t_edge;
	mem[12'hfff] <= 8'ha5;
	mv(12'hf80, 16'heb7f, 16'hf000, 12'h000, 8'ha5);
endtask
task t_ind;
	mem[12'hff0] <= 8'h5a;
	mv(12'hfe0, 16'heb10, 16'hf200, 12'h200, 8'h00);
endtask
task t_ss;
	mem[12'h085] <= 8'h44;
	mv(12'h080, 16'heb85, 16'hf006, 12'h086, 8'h44);
	// an indexed destination on an indirect register must leave it untouched
	mem[12'hf85] <= 8'h66;
	mem[12'hff1] <= 8'h99;
	mv(12'hf80, 16'heb85, 16'hf071, 12'hff1, 8'h99);
endtask
task t_call;
	put(16'h0014);
	repeat (8) @(posedge ref_clk);
	chk(push_v, 21'h000102);
	chk(load_v, 21'h001006);
endtask
task t_bad;
	mem[12'h123] <= 8'h77;
	mv(12'h080, 16'heb05, 16'h0123, 12'h123, 8'h77);
	chk(n_err, 21'h1);
endtask
task wrap_up;
	$display("compared %0d failed %0d", n_compared, n_fail);
	if (n_fail == 0 && n_compared > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
initial
begin
	repeat (6) @(posedge ref_clk);
	sys_rst <= 1'h0;
	t_file;
	t_edge;
	t_ind;
	t_ss;
	t_call;
	t_bad;
	wrap_up;
end
endmodule // tb_top

/* File: rtl/ixm_defines.vh */
`ifndef IXM_DEFINES_VH
`define IXM_DEFINES_VH

// ----------------------------------------
// instruction cycle phases
// ----------------------------------------
`define IXM_Q1 2'h0
`define IXM_Q2 2'h1
`define IXM_Q3 2'h2
`define IXM_Q4 2'h3

// ----------------------------------------
// opcode prefixes, select bit and call word
// ----------------------------------------
`define IXM_MOVE_PREFIX 8'heb
`define IXM_SEL_BIT 7
`define IXM_WORD2_PREFIX 4'hf
`define IXM_CALL_W_WORD 16'h0014

// ----------------------------------------
// indirect access registers (arbitrary placement)
// ----------------------------------------
`define IXM_IND0_ADDR 12'hff0
`define IXM_IND1_ADDR 12'hff1
`define IXM_IND2_ADDR 12'hff2
`define IXM_IND_READ_VALUE 8'h00

// ----------------------------------------
// program counter step to the next instruction
// ----------------------------------------
`define IXM_PC_STEP 21'h000002

`endif

/* File: rtl/ixm_indexed_move_exec.v */
`timescale 1ns/1ps
`include "ixm_defines.vh"

module ixm_indexed_move_exec (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// instruction stream
	input wire instr_valid,
	input wire [15:0] instr_word,
	// core state
	input wire [11:0] frame_pointer,
	input wire [7:0] working_register,
	input wire [7:0] pc_high_latch,
	input wire [7:0] pc_upper_latch,
	input wire [20:0] pc_value,
	// data memory
	input wire [7:0] mem_rd_data,
	output reg mem_rd_en_q,
	output reg mem_wr_en_q,
	output reg [11:0] mem_addr_q,
	output reg [7:0] mem_wr_data_q,
	// stack and pc
	output reg stack_push_q,
	output reg [20:0] stack_push_data_q,
	output reg pc_load_q,
	output reg [20:0] pc_load_value_q,
	// status
	output reg [1:0] phase_q,
	output reg busy_q,
	output reg seq_error_q
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_FILE2 = 2'h1;
	localparam ST_INDEX2 = 2'h2;
	localparam ST_CALL2 = 2'h3;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function is_indirect;
		input [11:0] addr;
		begin
			is_indirect = (addr == `IXM_IND0_ADDR) || (addr == `IXM_IND1_ADDR) ||
				(addr == `IXM_IND2_ADDR);
		end
	endfunction

	// offset is unsigned; the sum wraps inside the 4 KB space
	function [11:0] fp_offset;
		input [11:0] fp;
		input [6:0] ofs;
		begin
			fp_offset = fp + {5'h00, ofs};
		end
	endfunction

	reg [1:0] state_q;
	reg [1:0] cyc_q;
	reg [6:0] src_ofs_q;
	reg [11:0] src_addr_q;
	reg [11:0] dst_addr_q;
	reg [7:0] data_q;
	reg dst_skip_q;
	reg second_q;

	wire take_q1 = (phase_q == `IXM_Q1) && instr_valid;
	wire is_move = (instr_word[15:8] == `IXM_MOVE_PREFIX);
	wire word2_ok = (instr_word[15:12] == `IXM_WORD2_PREFIX);

	// ----------------------------------------
	// phase counter and sequencer
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			phase_q <= `IXM_Q1;
			state_q <= ST_IDLE;
			cyc_q <= 2'h0;
			busy_q <= 1'b0;
			seq_error_q <= 1'b0;
			src_ofs_q <= 7'h00;
			src_addr_q <= 12'h000;
			dst_addr_q <= 12'h000;
			data_q <= 8'h00;
			dst_skip_q <= 1'b0;
			second_q <= 1'b0;
			mem_rd_en_q <= 1'b0;
			mem_wr_en_q <= 1'b0;
			mem_addr_q <= 12'h000;
			mem_wr_data_q <= 8'h00;
			stack_push_q <= 1'b0;
			stack_push_data_q <= 21'h000000;
			pc_load_q <= 1'b0;
			pc_load_value_q <= 21'h000000;
		end
		else
		begin
			phase_q <= phase_q + 2'h1;
			seq_error_q <= 1'b0;
			mem_rd_en_q <= 1'b0;
			mem_wr_en_q <= 1'b0;
			stack_push_q <= 1'b0;
			pc_load_q <= 1'b0;
			case (state_q)
			ST_IDLE:
			begin
				if (take_q1 && is_move)
				begin
					src_ofs_q <= instr_word[6:0];
					busy_q <= 1'b1;
					second_q <= 1'b0;
					state_q <= instr_word[`IXM_SEL_BIT] ? ST_INDEX2 : ST_FILE2;
				end
				else if (take_q1 && (instr_word == `IXM_CALL_W_WORD))
				begin
					busy_q <= 1'b1;
					second_q <= 1'b0;
					state_q <= ST_CALL2;
				end
			end
			ST_FILE2, ST_INDEX2:
			begin
				if (!second_q)
				begin
					// first cycle: form source address, read it in Q4
					if (phase_q == `IXM_Q2)
						src_addr_q <= fp_offset(frame_pointer, src_ofs_q);
					if (phase_q == `IXM_Q3)
					begin
						mem_rd_en_q <= 1'b1;
						mem_addr_q <= src_addr_q;
					end
					if (phase_q == `IXM_Q4)
					begin
						// indirect registers read as zero, never their target
						data_q <= is_indirect(src_addr_q) ? `IXM_IND_READ_VALUE : mem_rd_data;
						second_q <= 1'b1;
					end
				end
				else
				begin
					// second cycle: no dummy read, write in Q4
					if (phase_q == `IXM_Q1)
					begin
						if (!instr_valid || !word2_ok)
						begin
							// a bad second word aborts with no write
							seq_error_q <= 1'b1;
							busy_q <= 1'b0;
							state_q <= ST_IDLE;
						end
						else if (state_q == ST_FILE2)
						begin
							dst_addr_q <= instr_word[11:0];
							dst_skip_q <= 1'b0;
						end
						else
						begin
							dst_addr_q <= fp_offset(frame_pointer, instr_word[6:0]);
							dst_skip_q <= is_indirect(fp_offset(frame_pointer, instr_word[6:0]));
						end
					end
					if (phase_q == `IXM_Q3)
					begin
						// an indexed destination on an indirect register runs as a nop
						mem_wr_en_q <= !dst_skip_q;
						mem_addr_q <= dst_addr_q;
						mem_wr_data_q <= data_q;
					end
					if (phase_q == `IXM_Q4)
					begin
						busy_q <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
			end
			ST_CALL2:
			begin
				if (phase_q == `IXM_Q2)
				begin
					stack_push_q <= 1'b1;
					stack_push_data_q <= pc_value + `IXM_PC_STEP;
				end
				if (phase_q == `IXM_Q3)
				begin
					// push lands before the pc load so the return address is the old pc plus 2
					pc_load_q <= 1'b1;
					pc_load_value_q <= {pc_upper_latch[4:0], pc_high_latch, working_register};
				end
				if (phase_q == `IXM_Q4)
					cyc_q <= cyc_q + 2'h1;
				if ((phase_q == `IXM_Q4) && (cyc_q == 2'h1))
				begin
					// second cycle repeats the Q2 push and the Q3 pc load, then returns to idle
					cyc_q <= 2'h0;
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			end
			default:
			begin
				busy_q <= 1'b0;
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // ixm_indexed_move_exec
